/* File: pkg/cthk_consts.svh */
// constants for the cache and translation-buffer test register hooks
// assumes the including file is compiled after nothing else of this block
`ifndef CTHK_CONSTS_SVH
`define CTHK_CONSTS_SVH

// test register numbers
`define CTHK_TR_CDATA 3'h3
`define CTHK_TR_CSTAT 3'h4
`define CTHK_TR_CCTRL 3'h5
`define CTHK_TR_TCMD 3'h6
`define CTHK_TR_TDATA 3'h7

// cache control register fields
`define CTHK_CC_CODE_HI 1
`define CTHK_CC_CODE_LO 0
`define CTHK_CC_ENT_HI 3
`define CTHK_CC_ENT_LO 2
`define CTHK_CC_SET_HI 10
`define CTHK_CC_SET_LO 4

// cache status register fields
`define CTHK_CS_TAG_HI 31
`define CTHK_CS_TAG_LO 11
`define CTHK_CS_VALID 10
`define CTHK_CS_LRU_HI 9
`define CTHK_CS_LRU_LO 7
`define CTHK_CS_VALS_HI 6
`define CTHK_CS_VALS_LO 3

// translation command register fields
`define CTHK_TC_LA_HI 31
`define CTHK_TC_LA_LO 12
`define CTHK_TC_PROT_HI 11
`define CTHK_TC_PROT_LO 5
`define CTHK_TC_OP 0

// translation data register fields
`define CTHK_TD_PA_HI 31
`define CTHK_TD_PA_LO 12
`define CTHK_TD_PAGE_CACHE_DISABLE 11
`define CTHK_TD_PAGE_WRITE_THROUGH 10
`define CTHK_TD_LRU_HI 9
`define CTHK_TD_LRU_LO 7
`define CTHK_TD_HIT 4
`define CTHK_TD_WAY_HI 3
`define CTHK_TD_WAY_LO 2
`define CTHK_TD_MASK 32'hFFFFFF9C

// protection bit positions within the 7-bit field: V, D, D#, U, U#, W, W#
`define CTHK_PR_V 6
`define CTHK_PR_D 5
`define CTHK_PR_DN 4
`define CTHK_PR_U 3
`define CTHK_PR_UN 2
`define CTHK_PR_W 1
`define CTHK_PR_WN 0

// translation buffer geometry
`define CTHK_TLB_WAYS 4
`define CTHK_TLB_SETS 8
`define CTHK_TLB_SETB 3
`define CTHK_TLB_TAGB 17

`endif

/* File: pkg/cthk_pkg.sv */
// types shared by the cache and translation-buffer test hooks
// assumes cthk_consts.svh holds every field position and count
package cthk_pkg;

  typedef enum logic [1:0] {
    CTHK_IDLE = 2'h0,
    CTHK_CWAIT = 2'h1,
    CTHK_TWAIT = 2'h3
  } cthk_state_e;

  typedef enum logic [1:0] {
    CTHK_BUF = 2'h0,
    CTHK_CWR = 2'h1,
    CTHK_CRD = 2'h2,
    CTHK_FLUSH = 2'h3
  } cthk_code_e;

  typedef struct packed {
    cthk_state_e state;
    cthk_code_e code;
    logic [1:0] entry;
    logic [6:0] set;
    logic [31:0] status;
    logic [3:0][31:0] fill;
    logic [3:0][31:0] rdbuf;
    logic [31:0] tcmd;
    logic [31:0] tdata;
    logic [31:0] rdata;
    logic rvalid;
    logic busy;
    logic c_req;
    logic c_read;
    logic c_flush;
    logic bus_flush;
    logic tlb_start;
  } cthk_top_s;

  // tag entry: [20:4] address tag, [3] V, [2] D, [1] U, [0] W
  typedef struct packed {
    logic [3:0][7:0][21:0] data;
    logic [3:0][7:0][20:0] tag;
    logic [7:0][2:0] lru;
    logic done;
    logic hit;
    logic [19:0] pa;
    logic page_cache_disable;
    logic page_write_through;
    logic [2:0] plru;
    logic [1:0] way;
  } cthk_tlb_s;

endpackage

/* File: design/cthk_tlb.sv */
// translation buffer arrays with test write and test lookup
// assumes one start pulse at a time; result stands one cycle after start
`timescale 1ns/1ps
`include "cthk_consts.svh"

module cthk_tlb (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic lookup_i,
  input wire logic [19:0] la_i,
  input wire logic [6:0] prot_i,
  input wire logic [19:0] pa_i,
  input wire logic page_cache_disable_i,
  input wire logic page_write_through_i,
  input wire logic fixed_way_i,
  input wire logic [1:0] way_i,
  output logic done_o,
  output logic hit_o,
  output logic [19:0] pa_o,
  output logic page_cache_disable_o,
  output logic page_write_through_o,
  output logic [2:0] lru_o,
  output logic [1:0] way_o
);

  cthk_pkg::cthk_tlb_s r;
  cthk_pkg::cthk_tlb_s next_r;
  logic [`CTHK_TLB_SETB-1:0] set;
  logic [`CTHK_TLB_TAGB-1:0] tg;
  logic [`CTHK_TLB_WAYS-1:0] hitv;
  logic one_hit;
  logic [1:0] hway;
  logic [1:0] wway;

  // pseudo-LRU shared with the cache: b0 picks the pair, b1/b2 the way
  function automatic logic [1:0] plru_victim(input logic [2:0] l);
    plru_victim = l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
  endfunction

  function automatic logic [2:0] plru_touch(input logic [2:0] l, input logic [1:0] w);
    plru_touch = l;
    plru_touch[0] = ~w[1];
    if (w[1]) begin
      plru_touch[2] = ~w[0];
    end else begin
      plru_touch[1] = ~w[0];
    end
  endfunction

  // pair 00 never matches, 11 always, 01 needs 0, 10 needs 1
  function automatic logic pair_match(input logic b, input logic bn, input logic s);
    pair_match = (b & s) | (bn & ~s);
  endfunction

  function automatic logic [1:0] way_enc(input logic [3:0] v);
    way_enc = {v[3] | v[2], v[3] | v[1]};
  endfunction

  assign set = la_i[`CTHK_TLB_SETB-1:0];
  assign tg = la_i[19:`CTHK_TLB_SETB];

  genvar w;
  generate
    for (w = 0; w < `CTHK_TLB_WAYS; w = w + 1) begin : g_way
      assign hitv[w] = (r.tag[w][set][20:4] == tg)
        && (r.tag[w][set][3] == prot_i[`CTHK_PR_V])
        && pair_match(prot_i[`CTHK_PR_D], prot_i[`CTHK_PR_DN], r.tag[w][set][2])
        && pair_match(prot_i[`CTHK_PR_U], prot_i[`CTHK_PR_UN], r.tag[w][set][1])
        && pair_match(prot_i[`CTHK_PR_W], prot_i[`CTHK_PR_WN], r.tag[w][set][0]);
    end
  endgenerate

  // an address present in two ways of a set does not hit
  assign one_hit = (hitv != 4'h0) && ((hitv & (hitv - 4'h1)) == 4'h0);
  assign hway = way_enc(hitv);
  assign wway = fixed_way_i ? way_i : plru_victim(r.lru[set]);

  always_comb begin
    next_r = r;
    next_r.done = start_i;
    if (start_i && !lookup_i) begin
      next_r.data[wway][set] = {pa_i, page_cache_disable_i, page_write_through_i};
      next_r.tag[wway][set] = {tg, prot_i[`CTHK_PR_V], prot_i[`CTHK_PR_D],
        prot_i[`CTHK_PR_U], prot_i[`CTHK_PR_W]};
      next_r.lru[set] = plru_touch(r.lru[set], wway);
    end else if (start_i) begin
      next_r.hit = one_hit;
      next_r.plru = r.lru[set]; // state before this lookup's update
      if (one_hit) begin
        {next_r.pa, next_r.page_cache_disable, next_r.page_write_through} = r.data[hway][set];
        next_r.way = hway;
        next_r.lru[set] = plru_touch(r.lru[set], hway);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = r.done;
  assign hit_o = r.hit;
  assign pa_o = r.pa;
  assign page_cache_disable_o = r.page_cache_disable;
  assign page_write_through_o = r.page_write_through;
  assign lru_o = r.plru;
  assign way_o = r.way;

endmodule

/* File: design/cthk_top.sv */
// test register hooks for the on-chip cache and translation buffer
// assumes cache arrays sit outside on the same clock and answer with ack
`timescale 1ns/1ps
`include "cthk_consts.svh"

module cthk_top (
  input wire logic clk_i,
  input wire logic srst_i,
  // move-to / move-from test register
  input wire logic tr_wr_i,
  input wire logic tr_rd_i,
  input wire logic [2:0] tr_num_i,
  input wire logic [31:0] tr_wdata_i,
  output logic [31:0] tr_rdata_o,
  output logic tr_rvalid_o,
  output logic tr_busy_o,
  // invalidate instruction request
  input wire logic flush_instr_i,
  output logic flush_bus_cycle_o,
  // cache array port
  output logic cache_req_o,
  output logic cache_read_o,
  output logic [6:0] cache_set_o,
  output logic [1:0] cache_entry_o,
  output logic [127:0] cache_wline_o,
  output logic [20:0] cache_wtag_o,
  output logic cache_wvalid_o,
  output logic cache_flush_o,
  input wire logic cache_ack_i,
  input wire logic [127:0] cache_rline_i,
  input wire logic [20:0] cache_rtag_i,
  input wire logic cache_rvalid_i,
  input wire logic [2:0] cache_rlru_i,
  input wire logic [3:0] cache_rvalids_i
);

  cthk_pkg::cthk_top_s r;
  cthk_pkg::cthk_top_s next_r;
  logic tlb_done;
  logic tlb_hit;
  logic [19:0] tlb_pa;
  logic tlb_page_cache_disable;
  logic tlb_page_write_through;
  logic [2:0] tlb_lru;
  logic [1:0] tlb_way;

  // only defined fields of the data register are kept; the rest read zero
  function automatic logic [31:0] tdata_clean(input logic [31:0] v);
    tdata_clean = v & `CTHK_TD_MASK;
  endfunction

  // status register: only tag and valid are software writable
  function automatic logic [31:0] status_wr(input logic [31:0] old, input logic [31:0] v);
    status_wr = old;
    status_wr[`CTHK_CS_TAG_HI:`CTHK_CS_TAG_LO] = v[`CTHK_CS_TAG_HI:`CTHK_CS_TAG_LO];
    status_wr[`CTHK_CS_VALID] = v[`CTHK_CS_VALID];
  endfunction

  function automatic logic [31:0] cctrl_view(input cthk_pkg::cthk_code_e c,
                                             input logic [1:0] e, input logic [6:0] s);
    cctrl_view = '0;
    cctrl_view[`CTHK_CC_CODE_HI:`CTHK_CC_CODE_LO] = c;
    cctrl_view[`CTHK_CC_ENT_HI:`CTHK_CC_ENT_LO] = e;
    cctrl_view[`CTHK_CC_SET_HI:`CTHK_CC_SET_LO] = s;
  endfunction

  cthk_tlb u_tlb (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(r.tlb_start),
    .lookup_i(r.tcmd[`CTHK_TC_OP]),
    .la_i(r.tcmd[`CTHK_TC_LA_HI:`CTHK_TC_LA_LO]),
    .prot_i(r.tcmd[`CTHK_TC_PROT_HI:`CTHK_TC_PROT_LO]),
    .pa_i(r.tdata[`CTHK_TD_PA_HI:`CTHK_TD_PA_LO]),
    .page_cache_disable_i(r.tdata[`CTHK_TD_PAGE_CACHE_DISABLE]),
    .page_write_through_i(r.tdata[`CTHK_TD_PAGE_WRITE_THROUGH]),
    .fixed_way_i(r.tdata[`CTHK_TD_HIT]),
    .way_i(r.tdata[`CTHK_TD_WAY_HI:`CTHK_TD_WAY_LO]),
    .done_o(tlb_done),
    .hit_o(tlb_hit),
    .pa_o(tlb_pa),
    .page_cache_disable_o(tlb_page_cache_disable),
    .page_write_through_o(tlb_page_write_through),
    .lru_o(tlb_lru),
    .way_o(tlb_way)
  );

  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.c_req = 1'b0;
    next_r.c_flush = 1'b0;
    next_r.bus_flush = 1'b0;
    next_r.tlb_start = 1'b0;

    // normal invalidate announces itself on the bus
    if (flush_instr_i) begin
      next_r.c_flush = 1'b1;
      next_r.bus_flush = 1'b1;
    end

    unique case (r.state)
      cthk_pkg::CTHK_IDLE: begin
        // test registers change here only on the write strobe; cache read and lookup results later load status and data
        if (tr_wr_i) begin
          unique case (tr_num_i)
            `CTHK_TR_CDATA: begin
              if (r.code == cthk_pkg::CTHK_BUF) begin
                next_r.fill[r.entry] = tr_wdata_i;
              end
            end
            `CTHK_TR_CSTAT: begin
              next_r.status = status_wr(r.status, tr_wdata_i);
            end
            `CTHK_TR_CCTRL: begin
              next_r.code = cthk_pkg::cthk_code_e'(
                tr_wdata_i[`CTHK_CC_CODE_HI:`CTHK_CC_CODE_LO]);
              unique case (cthk_pkg::cthk_code_e'(
                tr_wdata_i[`CTHK_CC_CODE_HI:`CTHK_CC_CODE_LO]))
                cthk_pkg::CTHK_BUF: begin
                  next_r.entry = tr_wdata_i[`CTHK_CC_ENT_HI:`CTHK_CC_ENT_LO];
                end
                cthk_pkg::CTHK_CWR: begin
                  next_r.entry = tr_wdata_i[`CTHK_CC_ENT_HI:`CTHK_CC_ENT_LO];
                  next_r.set = tr_wdata_i[`CTHK_CC_SET_HI:`CTHK_CC_SET_LO];
                  next_r.c_req = 1'b1;
                  next_r.c_read = 1'b0;
                  next_r.state = cthk_pkg::CTHK_CWAIT;
                end
                cthk_pkg::CTHK_CRD: begin
                  next_r.entry = tr_wdata_i[`CTHK_CC_ENT_HI:`CTHK_CC_ENT_LO];
                  next_r.set = tr_wdata_i[`CTHK_CC_SET_HI:`CTHK_CC_SET_LO];
                  next_r.c_req = 1'b1;
                  next_r.c_read = 1'b1;
                  next_r.state = cthk_pkg::CTHK_CWAIT;
                end
                cthk_pkg::CTHK_FLUSH: begin
                  // set and entry fields ignored; no bus announcement
                  next_r.c_flush = 1'b1;
                  next_r.bus_flush = flush_instr_i;
                end
              endcase
            end
            `CTHK_TR_TCMD: begin
              next_r.tcmd = tr_wdata_i;
              next_r.tlb_start = 1'b1;
              next_r.state = cthk_pkg::CTHK_TWAIT;
            end
            `CTHK_TR_TDATA: begin
              next_r.tdata = tdata_clean(tr_wdata_i);
            end
            default: begin
            end
          endcase
        end else if (tr_rd_i) begin
          next_r.rvalid = 1'b1;
          unique case (tr_num_i)
            `CTHK_TR_CDATA: begin
              // only meaningful with buffer-access code selected
              next_r.rdata = (r.code == cthk_pkg::CTHK_BUF) ?
                r.rdbuf[r.entry] : 32'h0;
            end
            `CTHK_TR_CSTAT: begin
              next_r.rdata = r.status;
            end
            `CTHK_TR_CCTRL: begin
              next_r.rdata = cctrl_view(r.code, r.entry, r.set);
            end
            `CTHK_TR_TCMD: begin
              next_r.rdata = r.tcmd;
            end
            `CTHK_TR_TDATA: begin
              next_r.rdata = r.tdata;
            end
            default: begin
              next_r.rdata = 32'h0;
            end
          endcase
        end
      end

      cthk_pkg::CTHK_CWAIT: begin
        if (cache_ack_i) begin
          if (r.c_read) begin
            next_r.rdbuf = cache_rline_i;
            next_r.status[`CTHK_CS_TAG_HI:`CTHK_CS_TAG_LO] = cache_rtag_i;
            next_r.status[`CTHK_CS_VALID] = cache_rvalid_i;
            next_r.status[`CTHK_CS_LRU_HI:`CTHK_CS_LRU_LO] = cache_rlru_i;
            next_r.status[`CTHK_CS_VALS_HI:`CTHK_CS_VALS_LO] = cache_rvalids_i;
          end
          next_r.state = cthk_pkg::CTHK_IDLE;
        end
      end

      cthk_pkg::CTHK_TWAIT: begin
        if (tlb_done) begin
          if (r.tcmd[`CTHK_TC_OP]) begin
            // a write leaves the data register as software loaded it
            next_r.tdata[`CTHK_TD_HIT] = tlb_hit;
            if (tlb_hit) begin
              next_r.tdata[`CTHK_TD_PA_HI:`CTHK_TD_PA_LO] = tlb_pa;
              next_r.tdata[`CTHK_TD_PAGE_CACHE_DISABLE] = tlb_page_cache_disable;
              next_r.tdata[`CTHK_TD_PAGE_WRITE_THROUGH] = tlb_page_write_through;
              next_r.tdata[`CTHK_TD_LRU_HI:`CTHK_TD_LRU_LO] = tlb_lru;
              next_r.tdata[`CTHK_TD_WAY_HI:`CTHK_TD_WAY_LO] = tlb_way;
            end
          end
          next_r.state = cthk_pkg::CTHK_IDLE;
        end
      end

      default: begin
        next_r.state = cthk_pkg::CTHK_IDLE;
      end
    endcase

    // stalls the next instruction until the operation has landed
    next_r.busy = (next_r.state != cthk_pkg::CTHK_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tr_rdata_o = r.rdata;
  assign tr_rvalid_o = r.rvalid;
  assign tr_busy_o = r.busy;
  assign flush_bus_cycle_o = r.bus_flush;
  assign cache_req_o = r.c_req;
  assign cache_read_o = r.c_read;
  assign cache_set_o = r.set;
  assign cache_entry_o = r.entry;
  assign cache_wline_o = r.fill;
  assign cache_wtag_o = r.status[`CTHK_CS_TAG_HI:`CTHK_CS_TAG_LO];
  assign cache_wvalid_o = r.status[`CTHK_CS_VALID];
  assign cache_flush_o = r.c_flush;

endmodule

/* File: verification/cthk_top_checker.sv */
// timing checks for the cache and translation-buffer test hooks
// assumes it is bound to cthk_top and sees only that module's ports
`timescale 1ns/1ps
module cthk_top_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tr_wr_i,
  input wire logic tr_rd_i,
  input wire logic [2:0] tr_num_i,
  input wire logic [31:0] tr_wdata_i,
  input wire logic tr_rvalid_o,
  input wire logic tr_busy_o,
  input wire logic flush_instr_i,
  input wire logic flush_bus_cycle_o,
  input wire logic cache_req_o,
  input wire logic cache_read_o,
  input wire logic [6:0] cache_set_o,
  input wire logic [1:0] cache_entry_o,
  input wire logic cache_flush_o,
  input wire logic cache_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic ctl_wr;
  // a strobe while busy is dropped, so only idle writes count
  assign ctl_wr = tr_wr_i && !tr_busy_o && tr_num_i == 3'h5;
  a_read_gets_answer: assert property (
    tr_rd_i && !tr_wr_i && !tr_busy_o |=> tr_rvalid_o)
    else $error("test register read not answered");
  a_rvalid_has_cause: assert property (tr_rvalid_o |-> $past(tr_rd_i))
    else $error("read valid without a read");
  a_flush_stays_quiet: assert property (ctl_wr && tr_wdata_i[1:0] == 2'h3
    |=> cache_flush_o && !flush_bus_cycle_o && !tr_busy_o)
    else $error("register flush wrong");
  a_bus_cycle_cause: assert property (flush_bus_cycle_o |-> $past(flush_instr_i))
    else $error("flush bus cycle without instruction");
  a_cache_read_req: assert property (ctl_wr && tr_wdata_i[1:0] == 2'h2
    |=> cache_req_o && cache_read_o && tr_busy_o
    && cache_set_o == $past(tr_wdata_i[10:4]) && cache_entry_o == $past(tr_wdata_i[3:2]))
    else $error("cache read request wrong");
  a_cache_write_req: assert property (ctl_wr && tr_wdata_i[1:0] == 2'h1
    |=> cache_req_o && !cache_read_o && tr_busy_o)
    else $error("cache write request wrong");
  a_tlb_op_time: assert property (tr_wr_i && !tr_busy_o && tr_num_i == 3'h6
    |=> tr_busy_o [*2] ##1 !tr_busy_o)
    else $error("translation op timing wrong");
  a_ack_ends_busy: assert property (cache_ack_i && tr_busy_o |=> !tr_busy_o)
    else $error("busy stays after cache ack");
endmodule

bind cthk_top cthk_top_checker cthk_top_checker_i (.clk_i(clk_i), .srst_i(srst_i),
  .tr_wr_i(tr_wr_i), .tr_rd_i(tr_rd_i), .tr_num_i(tr_num_i), .tr_wdata_i(tr_wdata_i),
  .tr_rvalid_o(tr_rvalid_o), .tr_busy_o(tr_busy_o), .flush_instr_i(flush_instr_i),
  .flush_bus_cycle_o(flush_bus_cycle_o), .cache_req_o(cache_req_o),
  .cache_read_o(cache_read_o), .cache_set_o(cache_set_o), .cache_entry_o(cache_entry_o),
  .cache_flush_o(cache_flush_o), .cache_ack_i(cache_ack_i));

/* File: verification/tb_cthk_top.sv */
// self-checking bench for the cache and translation-buffer test hooks
// assumes the bench plays both software and a cache array that acks next cycle
`timescale 1ns/1ps
module tb_cthk_top;
  typedef struct {logic [31:0] td, cmd, exp, m;} cthk_row_s;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic tr_wr_i = 1'b0;
  logic tr_rd_i = 1'b0;
  logic flush_instr_i = 1'b0;
  logic cache_ack_i = 1'b0;
  logic [2:0] tr_num_i = 3'h0;
  logic [31:0] tr_wdata_i = 32'h0;
  logic [127:0] cache_rline_i = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic [20:0] cache_rtag_i = 21'h15555;
  logic cache_rvalid_i = 1'b1;
  logic [2:0] cache_rlru_i = 3'h5;
  logic [3:0] cache_rvalids_i = 4'hA;
  logic [31:0] tr_rdata_o;
  logic tr_rvalid_o, tr_busy_o, flush_bus_cycle_o, cache_req_o, cache_read_o;
  logic cache_wvalid_o, cache_flush_o, lr_read;
  logic [6:0] cache_set_o;
  logic [1:0] cache_entry_o;
  logic [127:0] cache_wline_o;
  logic [20:0] cache_wtag_o;
  logic [8:0] lr_loc;
  int bad_count = 0;
  int n_tests = 0;
  int n_flush = 0;
  int n_bus = 0;
  // tlb rows: data reg, command, expected data reg, compare mask
  cthk_row_s rows [11] = '{
    '{32'hABCDEB98, 32'h12345CC0, 32'h0, 32'h0},
    '{32'h0, 32'h12345CC1, 32'hABCDEA18, 32'hFFFFFF9C},
    '{32'h0, 32'h123458C1, 32'h0, 32'h10},
    '{32'h0, 32'h12345FE1, 32'hABCDEA18, 32'hFFFFFF9C},
    '{32'h0, 32'h12345AC1, 32'h0, 32'h10},
    '{32'h0, 32'h123457E1, 32'h0, 32'h10},
    '{32'h11111400, 32'h00005CC0, 32'h0, 32'h0},
    '{32'h0, 32'h00005CC1, 32'h11111790, 32'hFFFFFF9C},
    '{32'h0, 32'h12345CC1, 32'hABCDEB98, 32'hFFFFFF9C},
    '{32'h0, 32'h00005CC1, 32'h11111710, 32'hFFFFFF9C},
    '{32'h0, 32'h22345CC1, 32'h0, 32'h10}};

  cthk_top cthk_top_i (.clk_i(clk_i), .srst_i(srst_i), .tr_wr_i(tr_wr_i), .tr_rd_i(tr_rd_i),
    .tr_num_i(tr_num_i), .tr_wdata_i(tr_wdata_i), .tr_rdata_o(tr_rdata_o),
    .tr_rvalid_o(tr_rvalid_o), .tr_busy_o(tr_busy_o), .flush_instr_i(flush_instr_i),
    .flush_bus_cycle_o(flush_bus_cycle_o), .cache_req_o(cache_req_o),
    .cache_read_o(cache_read_o), .cache_set_o(cache_set_o), .cache_entry_o(cache_entry_o),
    .cache_wline_o(cache_wline_o), .cache_wtag_o(cache_wtag_o),
    .cache_wvalid_o(cache_wvalid_o), .cache_flush_o(cache_flush_o),
    .cache_ack_i(cache_ack_i), .cache_rline_i(cache_rline_i), .cache_rtag_i(cache_rtag_i),
    .cache_rvalid_i(cache_rvalid_i), .cache_rlru_i(cache_rlru_i),
    .cache_rvalids_i(cache_rvalids_i));

  always #5 clk_i = ~clk_i;

  // cache array stand-in: ack one cycle after each request
  always @(posedge clk_i) begin
    cache_ack_i <= cache_req_o;
    if (cache_req_o) begin
      lr_read <= cache_read_o;
      lr_loc <= {cache_set_o, cache_entry_o};
    end
    n_flush += int'(cache_flush_o === 1'b1);
    n_bus += int'(flush_bus_cycle_o === 1'b1);
  end

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // bounded wait; next strobe only once busy is low
  task automatic settle;
    for (int i = 0; i < 20; i++) begin
      #1;
      if (tr_busy_o === 1'b0) break;
      @(posedge clk_i);
    end
  endtask

  task automatic wr(input logic [2:0] n, input logic [31:0] d);
    @(posedge clk_i);
    tr_wr_i <= 1'b1;
    tr_num_i <= n;
    tr_wdata_i <= d;
    @(posedge clk_i);
    tr_wr_i <= 1'b0;
    settle();
  endtask

  task automatic rd(input logic [2:0] n, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk_i);
    tr_rd_i <= 1'b1;
    tr_num_i <= n;
    @(posedge clk_i);
    tr_rd_i <= 1'b0;
    #1;
    chk(tr_rvalid_o, 1'b1);
    chk(tr_rdata_o & m, exp & m);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({tr_busy_o, tr_rvalid_o, cache_req_o, tr_rdata_o}, 0);
    foreach (rows[i]) begin
      if (!rows[i].cmd[0]) wr(3'h7, rows[i].td);
      wr(3'h6, rows[i].cmd);
      if (rows[i].cmd[0]) rd(3'h7, rows[i].exp, rows[i].m);
    end
    rd(3'h6, 32'h22345CC1, '1);
    for (int k = 0; k < 4; k++) begin
      wr(3'h5, 32'(k) << 2);
      wr(3'h3, 32'hC0DE0000 + 32'(k));
    end
    chk(cache_wline_o, {32'hC0DE0003, 32'hC0DE0002, 32'hC0DE0001, 32'hC0DE0000});
    wr(3'h4, {21'h1ABCD, 1'b1, 10'h0});
    wr(3'h5, {21'h0, 7'h2A, 2'h1, 2'h1});
    chk({lr_read, lr_loc, cache_wtag_o, cache_wvalid_o}, {10'h0A9, 21'h1ABCD, 1'b1});
    wr(3'h5, {21'h0, 7'h55, 2'h3, 2'h2});
    chk({lr_read, lr_loc}, {1'b1, 7'h55, 2'h3});
    // status and control read back before any other access; line words only after buffer-access selects
    rd(3'h4, {21'h15555, 1'b1, 3'h5, 4'hA, 3'h0}, '1);
    rd(3'h5, {21'h0, 7'h55, 2'h3, 2'h2}, '1);
    rd(3'h3, 32'h0, '1);
    for (int k = 0; k < 4; k++) begin
      wr(3'h5, 32'(k) << 2);
      rd(3'h3, cache_rline_i[32 * k +: 32], '1);
    end
    wr(3'h5, 32'hFFFFFFFF);
    rd(3'h5, {21'h0, 7'h55, 2'h3, 2'h3}, '1);
    chk(n_flush * 16 + n_bus, 16);
    @(posedge clk_i);
    flush_instr_i <= 1'b1;
    @(posedge clk_i);
    flush_instr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(n_bus, 1);
    rd(3'h0, 32'h0, '1);
    // mid-run reset must empty the translation arrays
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    wr(3'h6, 32'h12345CC1);
    rd(3'h7, 32'h0, 32'h10);
    give_verdict();
  end
endmodule
